// ### tpm_checker.sv
// Purpose: port-level checks for tpm_top
// Assumes: one clock domain, asynchronous active-low reset
// Notes: keeps its own copy of the pin synchroniser and the few fields it needs
`timescale 1ns/1ns
module tpm_checker (
    input wire mclk_i,
    input wire reset_n_i,
    input wire [15:0] reg_addr_i,
    input wire reg_wr_i,
    input wire [7:0] reg_wdata_i,
    input wire reg_rd_i,
    input wire [7:0] reg_rdata_o,
    input wire mirror_request_pin_i,
    input wire vertical_invert_pad_i,
    input wire pix_valid_i,
    input wire pix_sof_i,
    input wire pix_sol_i,
    input wire [9:0] pix_data_i,
    input wire pix_valid_o,
    input wire pix_sof_o,
    input wire pix_sol_o,
    input wire [9:0] pix_data_o,
    input wire mirror_o,
    input wire flip_o
);
    reg en_r;
    reg sh_r;
    reg [1:0] mf_r;
    reg [1:0] s1_r;
    reg [1:0] s2_r;
    wire mapped_w = reg_addr_i == 16'h3820 || reg_addr_i == 16'h3821 || reg_addr_i == 16'h5080
        || reg_addr_i == 16'h5081;
    // ==========================================
    // shadow state
    always @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            en_r <= 1'h0;
            sh_r <= 1'h0;
            mf_r <= 2'h0;
            s1_r <= 2'h0;
            s2_r <= 2'h0;
        end else begin
            s1_r <= {vertical_invert_pad_i, mirror_request_pin_i};
            s2_r <= s1_r;
            // frame copy of the enable; the frame-start pixel itself uses the live bit
            if (pix_valid_i && pix_sof_i)
                sh_r <= en_r;
            if (reg_wr_i && reg_addr_i == 16'h5080)
                en_r <= reg_wdata_i[7];
            if (reg_wr_i && reg_addr_i == 16'h3821)
                mf_r[0] <= reg_wdata_i[2:1] == 2'h3;
            if (reg_wr_i && reg_addr_i == 16'h3820)
                mf_r[1] <= reg_wdata_i[2:1] == 2'h3;
        end
    end
    // ==========================================
    // assertions
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!reset_n_i);
    sequence s_sof;
        pix_valid_i && pix_sof_i;
    endsequence
    sequence s_sol;
        pix_valid_i && pix_sol_i;
    endsequence
    a_valid_delay: assert property (pix_valid_i |=> pix_valid_o) else $error("valid not forwarded");
    a_valid_idle: assert property (!pix_valid_i |=> !pix_valid_o && !pix_sof_o && !pix_sol_o)
        else $error("output strobe without input pixel");
    a_sof_delay: assert property (s_sof |=> pix_sof_o && pix_sol_o) else $error("frame start lost");
    a_sol_delay: assert property (s_sol |=> pix_sol_o) else $error("line start lost");
    a_data_hold: assert property (!pix_valid_i |=> $stable(pix_data_o)) else $error("pixel moved idle");
    a_pass_thru: assert property (pix_valid_i && !(pix_sof_i ? en_r : sh_r) |=> pix_data_o == $past(pix_data_i))
        else $error("pixel altered with pattern off");
    a_mirror_hold: assert property (!(pix_valid_i && pix_sof_i) |=> $stable(mirror_o))
        else $error("mirror changed mid frame");
    a_flip_hold: assert property (!(pix_valid_i && pix_sof_i) |=> $stable(flip_o))
        else $error("flip changed mid frame");
    a_mirror_load: assert property (s_sof |=> mirror_o == ($past(s2_r[0]) | $past(mf_r[0])))
        else $error("mirror not pin or field");
    a_flip_load: assert property (s_sof |=> flip_o == ($past(s2_r[1]) | $past(mf_r[1])))
        else $error("flip not pin or field");
    a_read_unmapped: assert property (reg_rd_i && !mapped_w |=> reg_rdata_o == 8'h00)
        else $error("unmapped read not zero");
    a_read_hold: assert property (!reg_rd_i |=> $stable(reg_rdata_o)) else $error("read data moved");
endmodule // tpm_checker

bind tpm_top tpm_checker u_chk (.mclk_i, .reset_n_i, .reg_addr_i, .reg_wr_i, .reg_wdata_i, .reg_rd_i,
    .reg_rdata_o, .mirror_request_pin_i, .vertical_invert_pad_i, .pix_valid_i, .pix_sof_i, .pix_sol_i,
    .pix_data_i, .pix_valid_o, .pix_sof_o, .pix_sol_o, .pix_data_o, .mirror_o, .flip_o);

// ### tpm_regs.vh
// Purpose: constants for the test pattern, mirror and flip block
// Assumes: 8-bit registers at 16-bit addresses, 10-bit pixels
// Notes: definitions only
// Summary of operation
// - pattern control bit 7 turns test pattern output on or off.
// - mode field picks colour bars, random data, squares or black image.
// - bar style bits 3:2 pick standard or one of three darkening bar variants.
// - in square mode bit 4 picks colour squares or black-white squares.
// - bit 5 blends the pattern transparently with sensor data.
// - bit 6 overlays an inverted band moving down one step per frame.
// - fixed seed bit restarts the generator from the seed each frame.
// - random generator seed comes from the four-bit seed field.
// - mirror reverses pixel order in a row, flip reverses row order.
// - mirror and flip may be requested from pins or from registers.
// - mirror field bits 2:1, 00 off and 11 on; other codes forbidden.
// - flip field bits 2:1, 00 off and 11 on; other codes forbidden.
// - mirror pin low leaves mirror off, high turns it on.
// - flip pin low leaves flip off, high turns it on.
`ifndef TPM_REGS_VH
`define TPM_REGS_VH

// ==========================================================
// register addresses
`define TPM_ADDR_FLIP 16'h3820
`define TPM_ADDR_MIRROR 16'h3821
`define TPM_ADDR_PATTERN 16'h5080
`define TPM_ADDR_RANDOM 16'h5081

// ==========================================================
// reset values
`define TPM_RST_FLIP 8'h00
`define TPM_RST_MIRROR 8'h00
`define TPM_RST_PATTERN 8'h00
`define TPM_RST_RANDOM 8'h41

// ==========================================================
// field positions
`define TPM_FLD_ENABLE 7
`define TPM_FLD_BAND 6
`define TPM_FLD_SEE 5
`define TPM_FLD_SQKIND 4
`define TPM_FLD_STYLE_HI 3
`define TPM_FLD_STYLE_LO 2
`define TPM_FLD_MODE_HI 1
`define TPM_FLD_MODE_LO 0
`define TPM_FLD_FIXSEED 4
`define TPM_FLD_SEED_HI 3
`define TPM_FLD_SEED_LO 0
`define TPM_FLD_MF_HI 2
`define TPM_FLD_MF_LO 1

// ==========================================================
// encodings
`define TPM_MODE_BARS 2'h0
`define TPM_MODE_RANDOM 2'h1
`define TPM_MODE_SQUARES 2'h2
`define TPM_MODE_BLACK 2'h3
`define TPM_STYLE_STD 2'h0
`define TPM_STYLE_TOPBOT 2'h1
`define TPM_STYLE_RIGHTLEFT 2'h2
`define TPM_STYLE_BOTTOP 2'h3
`define TPM_MF_ON 2'h3

// ==========================================================
// geometry and timing counts
`define TPM_LAST_COL 10'h029F
`define TPM_LAST_ROW 10'h01EB
`define TPM_BAR_LAST 7'h53
`define TPM_PIX_FULL 10'h03FF
`define TPM_BAND_STEP 10'h0004
`define TPM_BAND_LAST 10'h001F

`endif

// ### tpm_rng.v
// Purpose: 16-bit pseudo random source for the random pattern
// Assumes: load has priority over step
// Notes: seed nibble is widened with a fixed nonzero tail so state never sticks at zero
`timescale 1ns/1ns
module tpm_rng (
    input wire mclk_i,
    input wire reset_n_i,
    input wire load_i,
    input wire [3:0] seed_i,
    input wire step_i,
    output wire [9:0] value_o
);
    reg [15:0] state_r;
    reg [15:0] state_nxt;
    wire feedback;

    // taps 16,14,13,11 give a maximal length sequence
    assign feedback = state_r[15] ^ state_r[13] ^ state_r[12] ^ state_r[10];

    always @* begin
        state_nxt = state_r;
        if (load_i) begin
            state_nxt = {seed_i, 12'hA51};
        end else if (step_i) begin
            state_nxt = {state_r[14:0], feedback};
        end
    end

    always @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_r <= 16'h0001;
        end else begin
            state_r <= state_nxt;
        end
    end

    // shows the state being entered, so a frame's first pixel already carries the reloaded seed
    assign value_o = state_nxt[9:0];
endmodule // tpm_rng

// ### tpm_sink.sv
// Purpose: downstream pipeline stand-in that records each frame
// Assumes: no back-pressure, one pixel per valid cycle
// Notes: keeps the first 127 pixels of a frame in arrival order; the last slot then holds the latest pixel
`timescale 1ns/1ns
module tpm_sink (
    input wire mclk_i,
    input wire reset_n_i,
    input wire pix_valid_i,
    input wire pix_sof_i,
    input wire pix_sol_i,
    input wire [9:0] pix_data_i,
    output reg [7:0] err_o
);
    reg [9:0] pix_r [0:127];
    reg [6:0] idx_r;
    always @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            idx_r <= 7'h00;
            err_o <= 8'h00;
        end else if (pix_valid_i) begin
            // frame start must also open a line, else framing downstream breaks
            if (pix_sof_i && !pix_sol_i)
                err_o <= err_o + 8'h01;
            if (pix_sof_i) begin
                pix_r[0] <= pix_data_i;
                idx_r <= 7'h01;
            end else begin
                pix_r[idx_r] <= pix_data_i;
                idx_r <= idx_r + ((idx_r == 7'h7F) ? 7'h00 : 7'h01);
            end
        end
    end
endmodule // tpm_sink

// ### tpm_sync.v
// Purpose: two-flop synchroniser for asynchronous pins
// Assumes: each bit is an independent level
// Notes: first stage feeds only the second stage
`timescale 1ns/1ns
module tpm_sync #(
    parameter WIDTH = 2
) (
    input wire mclk_i,
    input wire reset_n_i,
    input wire [WIDTH-1:0] async_i,
    output wire [WIDTH-1:0] sync_o
);
    // ==========================================================
    // per-bit two stage chain
    genvar g;
    generate
        for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
            reg meta_r;
            reg stable_r;
            always @(posedge mclk_i or negedge reset_n_i) begin
                if (!reset_n_i) begin
                    meta_r <= 1'b0;
                    stable_r <= 1'b0;
                end else begin
                    meta_r <= async_i[g];
                    stable_r <= meta_r;
                end
            end
            assign sync_o[g] = stable_r;
        end
    endgenerate
endmodule // tpm_sync

// ### tpm_top.v
// Purpose: test pattern generator with mirror and flip mode resolution
// Assumes: stream inputs are on mclk_i; sof/sol pulse with the first pixel of a frame/line
// Notes: mirror/flip outputs steer the read-out address logic of the array
`timescale 1ns/1ns
`include "tpm_regs.vh"
module tpm_top (
    input wire mclk_i,
    input wire reset_n_i,
    input wire [15:0] reg_addr_i,
    input wire reg_wr_i,
    input wire [7:0] reg_wdata_i,
    input wire reg_rd_i,
    output reg [7:0] reg_rdata_o,
    input wire mirror_request_pin_i,
    input wire vertical_invert_pad_i,
    input wire pix_valid_i,
    input wire pix_sof_i,
    input wire pix_sol_i,
    input wire [9:0] pix_data_i,
    output reg pix_valid_o,
    output reg pix_sof_o,
    output reg pix_sol_o,
    output reg [9:0] pix_data_o,
    output reg mirror_o,
    output reg flip_o
);
    // ==========================================================
    // registers
    reg [7:0] flip_control_r;
    reg [7:0] mirror_control_r;
    reg [7:0] pattern_control_r;
    reg [7:0] random_pattern_control_r;
    reg [7:0] rdata_nxt;

    always @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            flip_control_r <= `TPM_RST_FLIP;
            mirror_control_r <= `TPM_RST_MIRROR;
            pattern_control_r <= `TPM_RST_PATTERN;
            random_pattern_control_r <= `TPM_RST_RANDOM;
        end else if (reg_wr_i) begin
            case (reg_addr_i)
                `TPM_ADDR_FLIP: flip_control_r <= reg_wdata_i;
                `TPM_ADDR_MIRROR: mirror_control_r <= reg_wdata_i;
                `TPM_ADDR_PATTERN: pattern_control_r <= reg_wdata_i;
                `TPM_ADDR_RANDOM: random_pattern_control_r <= reg_wdata_i;
                default: begin
                end
            endcase
        end
    end

    // unmapped addresses read zero
    always @* begin
        case (reg_addr_i)
            `TPM_ADDR_FLIP: rdata_nxt = flip_control_r;
            `TPM_ADDR_MIRROR: rdata_nxt = mirror_control_r;
            `TPM_ADDR_PATTERN: rdata_nxt = pattern_control_r;
            `TPM_ADDR_RANDOM: rdata_nxt = random_pattern_control_r;
            default: rdata_nxt = 8'h00;
        endcase
    end

    always @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_rd_i) begin
            reg_rdata_o <= rdata_nxt;
        end
    end

    // ==========================================================
    // mirror and flip resolution
    wire [1:0] pins_sync;
    wire mirror_req;
    wire flip_req;
    reg first_pixel_r;

    tpm_sync #(
        .WIDTH(2)
    ) u_sync (
        .mclk_i(mclk_i),
        .reset_n_i(reset_n_i),
        .async_i({vertical_invert_pad_i, mirror_request_pin_i}),
        .sync_o(pins_sync)
    );

    // forbidden codes 01/10 count as off, so a stray write cannot half-enable
    assign mirror_req = pins_sync[0] |
        (mirror_control_r[`TPM_FLD_MF_HI:`TPM_FLD_MF_LO] == `TPM_MF_ON);
    assign flip_req = pins_sync[1] |
        (flip_control_r[`TPM_FLD_MF_HI:`TPM_FLD_MF_LO] == `TPM_MF_ON);

    wire frame_start;
    assign frame_start = pix_valid_i & pix_sof_i;

    // applied only between frames so one frame never mixes two read-out orders
    always @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            mirror_o <= 1'b0;
            flip_o <= 1'b0;
            first_pixel_r <= 1'b1;
        end else begin
            first_pixel_r <= 1'b0;
            if (frame_start | first_pixel_r) begin
                mirror_o <= mirror_req;
                flip_o <= flip_req;
            end
        end
    end

    // ==========================================================
    // frame shadow of pattern settings
    reg [7:0] pat_sh_r;
    reg [9:0] band_top_r;
    reg frames_seen_r;

    wire [9:0] band_top_step;
    assign band_top_step = band_top_r + `TPM_BAND_STEP;

    always @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pat_sh_r <= `TPM_RST_PATTERN;
            band_top_r <= 10'h0000;
            frames_seen_r <= 1'b0;
        end else if (frame_start) begin
            pat_sh_r <= pattern_control_r;
            frames_seen_r <= 1'b1;
            // band walks down each frame and wraps back to the top
            if (!pattern_control_r[`TPM_FLD_BAND]) begin
                band_top_r <= 10'h0000;
            end else if (band_top_step > `TPM_LAST_ROW) begin
                band_top_r <= 10'h0000;
            end else if (frames_seen_r) begin
                band_top_r <= band_top_step;
            end
        end
    end

    wire pat_en;
    wire band_en;
    wire see_en;
    wire sq_bw;
    wire [1:0] style;
    wire [1:0] mode;
    assign pat_en = pat_sh_r[`TPM_FLD_ENABLE];
    assign band_en = pat_sh_r[`TPM_FLD_BAND];
    assign see_en = pat_sh_r[`TPM_FLD_SEE];
    assign sq_bw = pat_sh_r[`TPM_FLD_SQKIND];
    assign style = pat_sh_r[`TPM_FLD_STYLE_HI:`TPM_FLD_STYLE_LO];
    assign mode = pat_sh_r[`TPM_FLD_MODE_HI:`TPM_FLD_MODE_LO];

    // ==========================================================
    // pixel position tracking
    reg [9:0] col_r;
    reg [9:0] row_r;
    reg [6:0] bar_cnt_r;
    reg [2:0] bar_idx_r;
    reg [9:0] cur_col;
    reg [9:0] cur_row;
    reg [6:0] cur_bar_cnt;
    reg [2:0] cur_bar;

    always @* begin
        cur_col = pix_sol_i ? 10'h0000 : col_r;
        cur_row = pix_sof_i ? 10'h0000 : (pix_sol_i ? row_r + 10'h0001 : row_r);
        cur_bar_cnt = pix_sol_i ? 7'h00 : bar_cnt_r;
        cur_bar = pix_sol_i ? 3'h0 : bar_idx_r;
    end

    always @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            col_r <= 10'h0000;
            row_r <= 10'h0000;
            bar_cnt_r <= 7'h00;
            bar_idx_r <= 3'h0;
        end else if (pix_valid_i) begin
            col_r <= cur_col + 10'h0001;
            row_r <= cur_row;
            if (cur_bar_cnt == `TPM_BAR_LAST) begin
                bar_cnt_r <= 7'h00;
                bar_idx_r <= cur_bar + 3'h1;
            end else begin
                bar_cnt_r <= cur_bar_cnt + 7'h01;
                bar_idx_r <= cur_bar;
            end
        end
    end

    // ==========================================================
    // random source
    wire [9:0] rnd_value;
    wire rnd_load;
    // fixed seed restarts each frame; free-running otherwise after the first load
    assign rnd_load = frame_start &
        (random_pattern_control_r[`TPM_FLD_FIXSEED] | !frames_seen_r);

    tpm_rng u_rng (
        .mclk_i(mclk_i),
        .reset_n_i(reset_n_i),
        .load_i(rnd_load),
        .seed_i(random_pattern_control_r[`TPM_FLD_SEED_HI:`TPM_FLD_SEED_LO]),
        .step_i(pix_valid_i),
        .value_o(rnd_value)
    );

    // ==========================================================
    // pattern value
    reg [2:0] colour_idx;
    reg chan_on;
    reg [9:0] level;
    reg [9:0] pat_val;
    reg [9:0] out_val;
    reg [10:0] blend_sum;
    reg in_band;

    always @*begin
        colour_idx = cur_bar;
        level = `TPM_PIX_FULL;
        chan_on = 1'b0;
        pat_val = 10'h0000;
        blend_sum = 11'h000;
        in_band = 1'b0;
        out_val = pix_data_i;
        // darkening slope per bar style
        case (style)
            `TPM_STYLE_STD: level = `TPM_PIX_FULL;
            `TPM_STYLE_TOPBOT: level = `TPM_PIX_FULL - cur_row;
            `TPM_STYLE_RIGHTLEFT: level = `TPM_PIX_FULL - (`TPM_LAST_COL - cur_col);
            `TPM_STYLE_BOTTOP: level = `TPM_PIX_FULL - (`TPM_LAST_ROW - cur_row);
            default: level = `TPM_PIX_FULL;
        endcase
        if (mode == `TPM_MODE_SQUARES) begin
            // 16x16 cells
            colour_idx = {cur_row[5], cur_col[5], cur_row[4] ^ cur_col[4]};
            level = `TPM_PIX_FULL;
        end
        // bayer site: even rows B G, odd rows G R; idx bits map to ~g,~r,~b
        if (!cur_row[0]) begin
            chan_on = cur_col[0] ? !colour_idx[2] : !colour_idx[0];
        end else begin
            chan_on = cur_col[0] ? !colour_idx[1] : !colour_idx[2];
        end
        case (mode)
            `TPM_MODE_BARS: pat_val = chan_on ? level : 10'h0000;
            `TPM_MODE_RANDOM: pat_val = rnd_value;
            `TPM_MODE_SQUARES: begin
                if (sq_bw) begin
                    pat_val = (cur_row[4] ^ cur_col[4]) ? `TPM_PIX_FULL : 10'h0000;
                end else begin
                    pat_val = chan_on ? `TPM_PIX_FULL : 10'h0000;
                end
            end
            `TPM_MODE_BLACK: pat_val = 10'h0000;
            default: pat_val = 10'h0000;
        endcase
        in_band = band_en && (cur_row >= band_top_r) && (cur_row <= band_top_r + `TPM_BAND_LAST);
        if (in_band) begin
            pat_val = ~pat_val;
        end
        if (see_en) begin
            // averaging keeps the scene visible behind the pattern
            blend_sum = {1'b0, pat_val} + {1'b0, pix_data_i};
            pat_val = blend_sum[10:1];
        end
        if (pat_en) begin
            out_val = pat_val;
        end else begin
            out_val = pix_data_i;
        end
    end

    // ==========================================================
    // output stage
    // the frame's first pixel sees the new shadow only a cycle late, so gate it with the live enable
    // bit as well as the old shadow enable; its other pattern fields still come from the old shadow
    reg [9:0] first_val;
    always @* begin
        first_val = pattern_control_r[`TPM_FLD_ENABLE] ? out_val : pix_data_i;
    end

    always @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pix_valid_o <= 1'b0;
            pix_sof_o <= 1'b0;
            pix_sol_o <= 1'b0;
            pix_data_o <= 10'h0000;
        end else begin
            pix_valid_o <= pix_valid_i;
            pix_sof_o <= pix_valid_i & pix_sof_i;
            pix_sol_o <= pix_valid_i & pix_sol_i;
            if (pix_valid_i) begin
                pix_data_o <= frame_start ? first_val : out_val;
            end
        end
    end
endmodule // tpm_top

// ### tpm_top_tb.sv
// Purpose: self-checking bench for tpm_top
// Assumes: short frames stand in for the full array
// Notes: a one-pixel frame after each pattern write absorbs the frame-start latch
`timescale 1ns/1ns
module tpm_top_tb;
    logic mclk_i = 1'h0;
    logic reset_n_i, wr_i, rd_i, mir_i, flp_i, pv_i, sof_i, sol_i;
    logic [15:0] addr_i;
    logic [7:0] wd_i;
    logic [9:0] pd_i, sdat;
    wire [7:0] rdata, serr;
    wire pv_o, sof_o, sol_o, mirror_o, flip_o;
    wire [9:0] pd_o;
    int fails = 0;
    int check_count = 0;
    int fa, fb, cnt, dif, pv;
    // bit0 mirror pin, bit1 mirror field, bit2 flip pin, bit3 flip field
    int ms [0:4] = '{0, 1, 8, 4, 2};
    logic [9:0] sv [0:15];
    logic [9:0] e0 [0:3] = '{10'h3FF, 10'h3FF, 10'h160, 10'h214};
    logic [9:0] e87 [0:3] = '{10'h3FF, 10'h3FE, 10'h161, 10'h215};
    always #25 mclk_i = ~mclk_i;
    tpm_top u_dut (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .reg_addr_i(addr_i), .reg_wr_i(wr_i),
        .reg_wdata_i(wd_i), .reg_rd_i(rd_i), .reg_rdata_o(rdata), .mirror_request_pin_i(mir_i),
        .vertical_invert_pad_i(flp_i), .pix_valid_i(pv_i), .pix_sof_i(sof_i), .pix_sol_i(sol_i),
        .pix_data_i(pd_i), .pix_valid_o(pv_o), .pix_sof_o(sof_o), .pix_sol_o(sol_o), .pix_data_o(pd_o),
        .mirror_o(mirror_o), .flip_o(flip_o));
    tpm_sink u_sink (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .pix_valid_i(pv_o), .pix_sof_i(sof_o),
        .pix_sol_i(sol_o), .pix_data_i(pd_o), .err_o(serr));
    // ==========================================
    // access tasks
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge mclk_i);
        addr_i = a;
        wd_i = d;
        wr_i = 1'h1;
        @(negedge mclk_i);
        wr_i = 1'h0;
    endtask
    task rd(input logic [15:0] a, input logic [7:0] e);
        @(negedge mclk_i);
        addr_i = a;
        rd_i = 1'h1;
        @(negedge mclk_i);
        rd_i = 1'h0;
        chk({8'h00, rdata}, {8'h00, e});
    endtask
    task frm(input int rows, input int px);
        for (int r = 0; r < rows; r++) begin
            for (int c = 0; c < px; c++) begin
                @(negedge mclk_i);
                pv_i = 1'h1;
                sof_i = r == 0 && c == 0;
                sol_i = c == 0;
                pd_i = sdat;
            end
        end
        @(negedge mclk_i);
        pv_i = 1'h0;
        sof_i = 1'h0;
        sol_i = 1'h0;
        repeat (2) @(negedge mclk_i);
    endtask
    task cfg(input logic [7:0] v);
        wr(16'h5080, v);
        frm(1, 1);
    endtask
    // compares a 16-pixel frame with the previous one, then keeps it
    task snap;
        dif = 0;
        for (int k = 0; k < 16; k++) begin
            if (u_sink.pix_r[k] !== sv[k])
                dif++;
            sv[k] = u_sink.pix_r[k];
        end
    endtask
    task band_find(output int first);
        first = -1;
        cnt = 0;
        for (int k = 39; k >= 0; k--) begin
            if (u_sink.pix_r[k] === 10'h3FF) begin
                first = k;
                cnt++;
            end
        end
    endtask
    task close_out;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge mclk_i);
        fails++;
        close_out;
    end
    // ==========================================
    // tests
    initial begin
        {reset_n_i, wr_i, rd_i, mir_i, flp_i, pv_i, sof_i, sol_i} = 8'h00;
        addr_i = 16'h0000;
        wd_i = 8'h00;
        pd_i = 10'h000;
        sdat = 10'h155;
        repeat (4) @(posedge mclk_i);
        @(negedge mclk_i);
        reset_n_i = 1'h1;
        rd(16'h3820, 8'h00);
        rd(16'h3821, 8'h00);
        rd(16'h5080, 8'h00);
        rd(16'h5081, 8'h41);
        wr(16'h5081, 8'h5A);
        rd(16'h5081, 8'h5A);
        wr(16'h1234, 8'hFF);
        rd(16'h1234, 8'h00);
        $display("test registers done");
        frm(1, 2);
        chk(u_sink.pix_r[1], 10'h155);
        cfg(8'h83);
        frm(1, 2);
        chk(u_sink.pix_r[1], 10'h000);
        sdat = 10'h200;
        cfg(8'hA3);
        frm(1, 2);
        chk(u_sink.pix_r[1], 10'h100);
        $display("test pass and black done");
        for (int s = 0; s < 4; s++) begin
            cfg(8'h80 | (s << 2));
            frm(2, 86);
            chk(u_sink.pix_r[0], e0[s]);
            chk(u_sink.pix_r[84], 10'h000);
            chk(u_sink.pix_r[87], e87[s]);
        end
        cfg(8'h82);
        frm(1, 17);
        chk(u_sink.pix_r[0], 10'h3FF);
        chk(u_sink.pix_r[16], 10'h000);
        cfg(8'h92);
        frm(1, 17);
        chk(u_sink.pix_r[0], 10'h000);
        chk(u_sink.pix_r[16], 10'h3FF);
        $display("test bars and squares done");
        wr(16'h5081, 8'h13);
        cfg(8'h81);
        frm(1, 16);
        snap;
        frm(1, 16);
        snap;
        chk(dif, 0);
        wr(16'h5081, 8'h14);
        frm(1, 1);
        frm(1, 16);
        snap;
        chk(dif != 0, 1);
        wr(16'h5081, 8'h04);
        frm(1, 16);
        snap;
        frm(1, 16);
        snap;
        chk(dif != 0, 1);
        $display("test random done");
        cfg(8'hC3);
        frm(40, 1);
        band_find(fa);
        chk(cnt, 32);
        frm(40, 1);
        band_find(fb);
        chk(fb, fa + 4);
        $display("test band done");
        pv = 0;
        for (int k = 0; k < 5; k++) begin
            // only 00 and 11 are ever written to the two fields
            wr(16'h3821, ms[k][1] ? 8'h06 : 8'h00);
            wr(16'h3820, ms[k][3] ? 8'h06 : 8'h00);
            mir_i = ms[k][0];
            flp_i = ms[k][2];
            repeat (3) @(negedge mclk_i);
            chk(mirror_o, pv[0]);
            chk(flip_o, pv[1]);
            frm(1, 1);
            pv = {ms[k][3] | ms[k][2], ms[k][1] | ms[k][0]};
            chk(mirror_o, pv[0]);
            chk(flip_o, pv[1]);
        end
        chk(serr, 8'h00);
        $display("test mirror and flip done");
        close_out;
    end
endmodule // tpm_top_tb
